//--- src/pfs_top.sv
// PWM generator fault select, fault override and secondary ADC trigger with Avalon-MM registers
//
// What this block does
// - Source codes 1 to 8 pick fault pins
// - Codes 13 and 14 pick comparators
// - Polarity one means active low source
// - Mode 11 ignores fault; 10 reserved
// - Mode 01 overrides outputs cycle by cycle
// - Mode 00 overrides outputs and latches
// - 13-bit compare in 15:3 triggers ADC
// - Compare bits 2:0 read as zero
// - Compare match never raises PWM interrupt
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`include "pfs_cfg.svh"
`default_nettype none
module pfs_top
   import pfs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // Avalon-MM slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Fault sources
   input  wire logic [7:0]  fault_pin,
   input  wire logic        comparator1,
   input  wire logic        comparator2,
   // Generator outputs before the fault override
   input  wire logic        pwm_high_in,
   input  wire logic        pwm_low_in,
   // Overridden outputs and ADC trigger
   output logic             pwm_high_output,
   output logic             pwm_low_output,
   output logic             adc_trigger
);

   // Register map, byte offsets on the Avalon-MM side:
   //   0x00 fault control: source in 7:3, polarity in 2, mode in 1:0
   //   0x04 secondary compare: value in 15:3, bits 2:0 read zero
   //   0x08 fault levels: high output level in 1, low in 0
   //   0x0C status: latched in 0 (write one clears), override in 1,
   //        fault active in 2; bits 1 and 2 are read only
   //   0x10 local period, counter runs 0 to period inclusive
   //   0x14 time base: module enable in 15, local time base in 0
   // Only byte lanes 0 and 1 are used; lanes 2 and 3 are ignored and
   // the upper half of every read is zero.
   //
   // Latency through the fault path, in clock edges after the pin moves:
   //   edge 1 registers the polarity-corrected level,
   //   edge 2 sets the override flag,
   //   edge 3 puts the fault levels on the outputs.
   // The extra flop on the source costs a cycle but keeps the wide
   // source mux out of the path to the output flops.
   //
   // Cycle-by-cycle release waits for a period boundary, so a short
   // fault pulse still blanks the rest of that period.
   // With the module disabled there is no boundary, so a cycle override
   // stays until the mode is changed; software must re-enable the module.
   //
   // The latch keeps its state across a mode change on purpose: a trip
   // stays visible in status until software acknowledges it.
   //
   // Reset leaves mode 00 with source 00000; the reserved source never
   // signals a fault, so the latch cannot set until a source is chosen.
   //
   // Software should stop the module before it changes the polarity:
   // the registered level flips at once and may look like a new fault.

   // Register storage
   pfs_reg_t   fault_limit_control_r;        // Source, polarity, mode
   logic [12:0] secondary_compare_value_r;   // Compare bits 15:3
   logic [1:0] fault_output_values_r;        // High and low fault levels
   pfs_reg_t   period_r;                     // Local time base period
   pfs_reg_t   pwm_time_base_control_r;      // Enable and local select
   pfs_reg_t   tb_cnt_r;                     // Local time base counter

   // Fault state
   logic       fault_active;                 // Registered, polarity applied
   logic       cycle_override_r;             // Cycle-by-cycle override
   logic       latched_r;                    // Latched override
   logic       override;                     // Either override in force

   // Bus state
   logic       wait_r;                       // Drives waitrequest
   logic [31:0] readdata_r;                  // Read data holding flop
   logic       req;                          // Master is requesting
   logic       wr_take;                      // Write takes effect this edge
   logic       rd_load;                      // Read data loaded this edge
   logic [31:0] rd_mux;                      // Read data before the flop

   // Output flops
   logic       pwm_high_r;
   logic       pwm_low_r;
   logic       adc_trigger_r;

   // Decoded fields
   logic [4:0] fault_source_select;
   logic       fault_polarity;
   pfs_mode_e  fault_response_mode;
   logic       pwm_module_enable;
   logic       local_time_base;
   logic       boundary;                     // End of a local period
   logic       clear_latch;                  // Software write-one-to-clear

   // Field extraction
   assign fault_source_select = fault_limit_control_r[`PFS_SRC_HI:`PFS_SRC_LO];
   assign fault_polarity      = fault_limit_control_r[`PFS_POL_BIT];
   assign fault_response_mode = pfs_mode_e'(fault_limit_control_r[`PFS_MODE_HI:`PFS_MODE_LO]);
   assign pwm_module_enable   = pwm_time_base_control_r[`PFS_TB_ENABLE];
   assign local_time_base     = pwm_time_base_control_r[`PFS_TB_LOCAL];

   // Bus handshake terms
   assign req     = read | write;
   assign wr_take = write & ~wait_r;
   assign rd_load = read & wait_r;

   // Avalon outputs come straight from flops
   assign readdata    = readdata_r;
   assign waitrequest = wait_r;

   // Block outputs come straight from flops
   assign pwm_high_output = pwm_high_r;
   assign pwm_low_output  = pwm_low_r;
   assign adc_trigger     = adc_trigger_r;

   // Source selection and polarity live in the leaf
   pfs_fault_sel u_sel (
      .clk                 (clk),
      .resetn              (resetn),
      .fault_pin           (fault_pin),
      .comparator1         (comparator1),
      .comparator2         (comparator2),
      .fault_source_select (fault_source_select),
      .fault_polarity      (fault_polarity),
      .active_r            (fault_active)
   );

   // One wait state per access: waitrequest drops for one cycle
   // after a request is seen, then rises again, so every access
   // takes exactly two edges and read data can be registered.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         wait_r <= 1'b1;
      else
         wait_r <= ~(req & wait_r);
   end

   // Read data mux; unmapped offsets read as zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (address)
         `PFS_OFS_FLT_CTRL:
            rd_mux[15:0] = fault_limit_control_r;
         `PFS_OFS_SEC_CMP:
            rd_mux[15:0] = {secondary_compare_value_r, 3'h0};
         `PFS_OFS_FDAT:
            rd_mux[1:0] = fault_output_values_r;
         `PFS_OFS_STATUS:
         begin
            rd_mux[`PFS_ST_LATCHED]  = latched_r;
            rd_mux[`PFS_ST_OVERRIDE] = override;
            rd_mux[`PFS_ST_ACTIVE]   = fault_active;
         end
         `PFS_OFS_PERIOD:
            rd_mux[15:0] = period_r;
         `PFS_OFS_TB_CTRL:
            rd_mux[15:0] = pwm_time_base_control_r;
         default:
            rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is loaded as waitrequest falls and held until the
   // next read, so it stands at the edge where the master samples it
   always_ff @(posedge clk)
   begin
      if (!resetn)
         readdata_r <= 32'h0000_0000;
      else if (rd_load)
         readdata_r <= rd_mux;
   end

   // Fault control register, byte-lane writes
   always_ff @(posedge clk)
   begin
      if (!resetn)
         fault_limit_control_r <= `PFS_RST_REG;
      else if (wr_take && address == `PFS_OFS_FLT_CTRL)
      begin
         // Upper byte holds no implemented field here
         if (byteenable[0])
            fault_limit_control_r[7:0] <= writedata[7:0];
      end
   end

   // Secondary compare; bits 2:0 are not stored at all
   always_ff @(posedge clk)
   begin
      if (!resetn)
         secondary_compare_value_r <= 13'h0000;
      else if (wr_take && address == `PFS_OFS_SEC_CMP)
      begin
         if (byteenable[0])
            secondary_compare_value_r[4:0] <= writedata[7:3];
         if (byteenable[1])
            secondary_compare_value_r[12:5] <= writedata[15:8];
      end
   end

   // Fault output levels
   always_ff @(posedge clk)
   begin
      if (!resetn)
         fault_output_values_r <= 2'h0;
      else if (wr_take && address == `PFS_OFS_FDAT && byteenable[0])
         fault_output_values_r <= writedata[1:0];
   end

   // Period register, resets to full range so the counter wraps
   always_ff @(posedge clk)
   begin
      if (!resetn)
         period_r <= `PFS_RST_PERIOD;
      else if (wr_take && address == `PFS_OFS_PERIOD)
      begin
         if (byteenable[0])
            period_r[7:0] <= writedata[7:0];
         if (byteenable[1])
            period_r[15:8] <= writedata[15:8];
      end
   end

   // Time base control; only the enable and local select exist
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pwm_time_base_control_r <= `PFS_RST_REG;
      else if (wr_take && address == `PFS_OFS_TB_CTRL)
      begin
         if (byteenable[0])
            pwm_time_base_control_r[`PFS_TB_LOCAL] <= writedata[`PFS_TB_LOCAL];
         if (byteenable[1])
            pwm_time_base_control_r[`PFS_TB_ENABLE] <= writedata[`PFS_TB_ENABLE];
      end
   end

   // Software clears the latch by writing one to status bit 0
   assign clear_latch = wr_take && address == `PFS_OFS_STATUS &&
                        byteenable[0] && writedata[`PFS_ST_LATCHED];

   // Local time base counter; stops and clears while disabled
   always_ff @(posedge clk)
   begin
      if (!resetn)
         tb_cnt_r <= 16'h0000;
      else if (!pwm_module_enable || boundary)
         tb_cnt_r <= 16'h0000;
      else
         tb_cnt_r <= tb_cnt_r + 16'h0001;
   end

   // Period boundary marks the last count of a period
   assign boundary = pwm_module_enable && (tb_cnt_r == period_r);

   // Cycle-by-cycle override: set by an active fault, released at
   // a boundary with the fault gone, or when the mode leaves 01. Set wins over the boundary release; leaving 01 wins over set.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         cycle_override_r <= 1'b0;
      else if (fault_response_mode != PFS_CYCLE)
         cycle_override_r <= 1'b0;
      else if (fault_active)
         cycle_override_r <= 1'b1;
      else if (boundary)
         cycle_override_r <= 1'b0;
   end

   // Latched override: held until software clears it; a fault still
   // present in the clearing cycle wins, so no event is lost.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         latched_r <= 1'b0;
      else if (fault_response_mode == PFS_LATCHED && fault_active)
         latched_r <= 1'b1;
      else if (clear_latch)
         latched_r <= 1'b0;
   end

   // Disabled and reserved modes take neither path above; a latch set
   // earlier still needs its clear, which keeps a trip visible.
   always_comb
   begin
      unique case (fault_response_mode)
         PFS_LATCHED:  override = latched_r;
         PFS_CYCLE:    override = cycle_override_r | latched_r;
         PFS_RESERVED: override = latched_r;
         PFS_DISABLED: override = latched_r;
      endcase
   end

   // Output stage: fault levels replace generator levels when forced
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pwm_high_r <= 1'b0;
         pwm_low_r  <= 1'b0;
      end
      else if (override)
      begin
         pwm_high_r <= fault_output_values_r[`PFS_FDAT_HIGH];
         pwm_low_r  <= fault_output_values_r[`PFS_FDAT_LOW];
      end
      else
      begin
         pwm_high_r <= pwm_high_in;
         pwm_low_r  <= pwm_low_in;
      end
   end

   // Secondary compare match goes to the ADC only; no interrupt path
   // exists, so a match can never be seen as a PWM trigger interrupt.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         adc_trigger_r <= 1'b0;
      else
         adc_trigger_r <= pwm_module_enable && local_time_base &&
                          (tb_cnt_r == {secondary_compare_value_r, 3'h0});
   end

endmodule : pfs_top
`default_nettype wire

//--- src/pfs_cfg.svh
// Register map, field positions, reset values and bus widths for the fault/trigger block
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// Bus widths
`define PFS_ADDR_W        5
`define PFS_DATA_W        32
`define PFS_REG_W         16

// Register byte offsets
`define PFS_OFS_FLT_CTRL  5'h00
`define PFS_OFS_SEC_CMP   5'h04
`define PFS_OFS_FDAT      5'h08
`define PFS_OFS_STATUS    5'h0C
`define PFS_OFS_PERIOD    5'h10
`define PFS_OFS_TB_CTRL   5'h14

// Fault control fields
`define PFS_SRC_HI        7
`define PFS_SRC_LO        3
`define PFS_POL_BIT       2
`define PFS_MODE_HI       1
`define PFS_MODE_LO       0

// Fault source codes
`define PFS_SRC_FLT_FIRST 5'h01
`define PFS_SRC_FLT_LAST  5'h08
`define PFS_SRC_CMP1      5'h0D
`define PFS_SRC_CMP2      5'h0E

// Fault response mode codes
`define PFS_MODE_LATCH    2'h0
`define PFS_MODE_CYCLE    2'h1
`define PFS_MODE_RSVD     2'h2
`define PFS_MODE_OFF      2'h3

// Secondary trigger compare field
`define PFS_SCMP_HI       15
`define PFS_SCMP_LO       3
`define PFS_SCMP_W        13

// Fault output data fields
`define PFS_FDAT_HIGH     1
`define PFS_FDAT_LOW      0

// Status fields (bit 0 is write-one-to-clear)
`define PFS_ST_LATCHED    0
`define PFS_ST_OVERRIDE   1
`define PFS_ST_ACTIVE     2

// Time base control fields
`define PFS_TB_ENABLE     15
`define PFS_TB_LOCAL      0

// Reset values
`define PFS_RST_REG       16'h0000
`define PFS_RST_PERIOD    16'hFFFF

`endif

//--- src/pfs_pkg.sv
// Types shared by the fault select and secondary trigger block
`default_nettype none
package pfs_pkg;
   // Fault response mode as held in the control register
   typedef enum logic [1:0] {
      PFS_LATCHED,
      PFS_CYCLE,
      PFS_RESERVED,
      PFS_DISABLED
   } pfs_mode_e;
   // One 16-bit register word
   typedef logic [15:0] pfs_reg_t;
endpackage : pfs_pkg
`default_nettype wire

//--- src/pfs_fault_sel.sv
// Fault source multiplexer with polarity, registered active flag
`include "pfs_cfg.svh"
`default_nettype none
module pfs_fault_sel
   import pfs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] fault_pin,
   input  wire logic       comparator1,
   input  wire logic       comparator2,
   input  wire logic [4:0] fault_source_select,
   input  wire logic       fault_polarity,
   output logic            active_r
);
   logic raw;       // Level of the chosen source
   logic valid;     // Code names a real source
   logic [4:0] idx; // Fault pin index

   // Source decode; reserved codes never signal a fault
   always_comb
   begin
      idx   = fault_source_select - 5'h01;
      raw   = 1'b0;
      valid = 1'b0;
      if (fault_source_select >= `PFS_SRC_FLT_FIRST &&
          fault_source_select <= `PFS_SRC_FLT_LAST)
      begin
         raw   = fault_pin[idx[2:0]];
         valid = 1'b1;
      end
      else if (fault_source_select == `PFS_SRC_CMP1)
      begin
         raw   = comparator1;
         valid = 1'b1;
      end
      else if (fault_source_select == `PFS_SRC_CMP2)
      begin
         raw   = comparator2;
         valid = 1'b1;
      end
   end

   // Polarity applied before registering, so a change shows next cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
         active_r <= 1'b0;
      else
         active_r <= valid & (raw ^ fault_polarity);
   end
endmodule : pfs_fault_sel
`default_nettype wire

//--- testbench/pfs_src_model.sv
// Far-side model: fault pins, comparators and raw generator levels
`default_nettype none
module pfs_src_model
(
   input  wire logic [9:0] src_on,
   output logic      [7:0] fault_pin,
   output logic            comparator1,
   output logic            comparator2,
   output logic            pwm_high_in,
   output logic            pwm_low_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins and comparators follow the bench request, bit 8/9 are the comparators
   assign fault_pin   = src_on[7:0];
   assign comparator1 = src_on[8];
   assign comparator2 = src_on[9];
   // Raw levels are the inverse of the fault data so any override shows
   assign pwm_high_in = 1'b0;
   assign pwm_low_in  = 1'b1;
endmodule : pfs_src_model
`default_nettype wire

//--- testbench/pfs_top_props.sv
// Port-level checker for the fault select and trigger block
`default_nettype none
module pfs_props
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest,
   input  wire logic        pwm_high_in,
   input  wire logic        pwm_low_in,
   input  wire logic        pwm_high_output,
   input  wire logic        pwm_low_output,
   input  wire logic        adc_trigger
);
   logic [1:0] mode_r; // Shadow of the response mode seen on the bus
   logic       tbl_r;  // Shadow of enable and local time base together
   wire        acc_w = write && !waitrequest; // Write lands this edge
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Track mode writes; only the low lane matters
   always_ff @(posedge clk)
      if (!resetn)
         mode_r <= 2'h0;
      else if (acc_w && address == 5'h00)
         mode_r <= writedata[1:0];
   // Track time base writes
   always_ff @(posedge clk)
      if (!resetn)
         tbl_r <= 1'b0;
      else if (acc_w && address == 5'h14)
         tbl_r <= writedata[15] && writedata[0];
   // A request seen while busy must be answered soon
   sequence s_req;
      (read || write) && waitrequest;
   endsequence
   sequence s_ans;
      ##[1:2] !waitrequest;
   endsequence
   chk_reset_idle:
      assert property (disable iff (1'b0) !resetn |=> waitrequest && !adc_trigger && !pwm_high_output
         && !pwm_low_output) else $error("outputs not idle after reset");
   chk_bus_answer:
      assert property (s_req |-> s_ans) else $error("bus request not answered");
   chk_wait_single:
      assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
   chk_read_upper:
      assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000) else $error("upper read bits set");
   chk_cmp_low:
      assert property (read && !waitrequest && address == 5'h04 |-> readdata[2:0] == 3'h0)
         else $error("compare low bits set");
   chk_pass_off:
      assert property (mode_r[1] && $past(mode_r[1], 3) |-> pwm_high_output == $past(pwm_high_in)
         && pwm_low_output == $past(pwm_low_in)) else $error("output forced while fault ignored");
   chk_trig_gate:
      assert property (adc_trigger |-> $past(tbl_r)) else $error("trigger without local time base");
   chk_trig_single:
      assert property (adc_trigger |=> !adc_trigger) else $error("trigger longer than one cycle");
endmodule : pfs_props
bind pfs_top pfs_props u_props (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pwm_high_in(pwm_high_in),
   .pwm_low_in(pwm_low_in), .pwm_high_output(pwm_high_output), .pwm_low_output(pwm_low_output),
   .adc_trigger(adc_trigger));
`default_nettype wire

//--- testbench/pfs_bench.sv
// Self-checking bench for the fault select and secondary trigger block
`include "pfs_cfg.svh"
`default_nettype none
module pwm_fault_select_and_secondary_trigger_bench;
   import pfs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk         = 1'b0;
   logic        resetn      = 1'b0;
   logic [4:0]  address     = 5'h00;
   logic        read        = 1'b0;
   logic        write       = 1'b0;
   logic [31:0] writedata   = 32'h00000000;
   logic [3:0]  byteenable  = 4'hF; // Whole-word accesses only
   logic [9:0]  src_on      = 10'h000; // Requested source levels
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  fault_pin;
   logic        comparator1, comparator2, pwm_high_in, pwm_low_in;
   logic        pwm_high_output, pwm_low_output, adc_trigger;
   int          fail_count  = 0;
   int          tests_run   = 0;
   wire  [1:0]  outs = {pwm_high_output, pwm_low_output};
   // Clock at 125 MHz
   always #4 clk = ~clk;
   pfs_top uut (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .fault_pin(fault_pin), .comparator1(comparator1), .comparator2(comparator2),
      .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in), .pwm_high_output(pwm_high_output),
      .pwm_low_output(pwm_low_output), .adc_trigger(adc_trigger));
   pfs_src_model u_src (.src_on(src_on), .fault_pin(fault_pin), .comparator1(comparator1),
      .comparator2(comparator2), .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in));
   // Verdict and stop
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // Compare one value
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One bus cycle; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [31:0] q);
      int n;
      n = 0;
      address <= a;
      writedata <= {16'h0000, d};
      write <= wr;
      read <= !wr;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 64);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 64)
         fail_count++;
      @(posedge clk);
   endtask : bus
   task automatic bw(input logic [4:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : bw
   // Read and compare
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(q, {16'h0000, e});
   endtask : rd
   // Count trigger pulses over two 64-cycle periods
   task automatic trig_count(input int e);
      int n;
      n = 0;
      repeat (128)
      begin
         @(posedge clk);
         if (adc_trigger === 1'b1)
            n++;
      end
      chk(n, e);
   endtask : trig_count
   // Stop, set the fault control, restart; keeps polarity changes off a running module
   task automatic cfg(input logic [15:0] v);
      bw(`PFS_OFS_TB_CTRL, 16'h0000);
      bw(`PFS_OFS_FLT_CTRL, v);
      bw(`PFS_OFS_TB_CTRL, 16'h8000);
   endtask : cfg
   // Reset values and an unmapped offset
   task automatic t_regs;
      rd(`PFS_OFS_FLT_CTRL, 16'h0000);
      rd(`PFS_OFS_SEC_CMP, 16'h0000);
      rd(`PFS_OFS_FDAT, 16'h0000);
      rd(`PFS_OFS_STATUS, 16'h0000);
      rd(`PFS_OFS_PERIOD, 16'hFFFF);
      rd(5'h18, 16'h0000);
      bw(`PFS_OFS_SEC_CMP, 16'hFFFF);
      rd(`PFS_OFS_SEC_CMP, 16'hFFF8);
      $display("test regs done");
   endtask : t_regs
   // Compare match only in the local time base while enabled
   task automatic t_trig;
      bw(`PFS_OFS_PERIOD, 16'h003F);
      bw(`PFS_OFS_SEC_CMP, 16'h0028);
      bw(`PFS_OFS_TB_CTRL, 16'h8001);
      trig_count(2);
      bw(`PFS_OFS_TB_CTRL, 16'h8000);
      trig_count(0);
      $display("test trig done");
   endtask : t_trig
   // Every valid source code in cycle mode; reserved codes 00, 09, 0F and 1F never fault
   task automatic t_src;
      logic [4:0] codes [14];
      codes = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0D, 5'h0E,
                5'h00, 5'h09, 5'h0F, 5'h1F};
      for (int i = 0; i < 14; i++)
      begin
         cfg({8'h00, codes[i], 3'b001});
         src_on <= (i < 10) ? (10'h001 << i) : 10'h3FF;
         repeat (6) @(posedge clk);
         chk(outs, (i < 10) ? 2'b10 : 2'b01);
         src_on <= 10'h000;
         repeat (24) @(posedge clk);
         chk(outs, 2'b01);
      end
      $display("test src done");
   endtask : t_src
   // Active-low source
   task automatic t_pol;
      src_on <= 10'h3FF;
      cfg(16'h000D);
      repeat (24) @(posedge clk);
      chk(outs, 2'b01);
      src_on <= 10'h3FE;
      repeat (6) @(posedge clk);
      chk(outs, 2'b10);
      // Park on a reserved source first, so dropping the pins cannot trip
      cfg(16'h0001);
      src_on <= 10'h000;
      $display("test pol done");
   endtask : t_pol
   // Latched mode holds until cleared, then disabled and reserved modes
   task automatic t_latch;
      cfg(16'h0008);
      rd(`PFS_OFS_STATUS, 16'h0000);
      src_on <= 10'h001;
      repeat (6) @(posedge clk);
      chk(outs, 2'b10);
      src_on <= 10'h000;
      repeat (40) @(posedge clk);
      chk(outs, 2'b10);
      rd(`PFS_OFS_STATUS, 16'h0003);
      bw(`PFS_OFS_STATUS, 16'h0001);
      repeat (4) @(posedge clk);
      chk(outs, 2'b01);
      cfg(16'h000B);
      src_on <= 10'h001;
      repeat (8) @(posedge clk);
      chk(outs, 2'b01);
      bw(`PFS_OFS_FLT_CTRL, 16'h000A);
      repeat (8) @(posedge clk);
      chk(outs, 2'b01);
      $display("test latch done");
   endtask : t_latch
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_regs;
      t_trig;
      bw(`PFS_OFS_PERIOD, 16'h000F);
      bw(`PFS_OFS_FDAT, 16'h0002);
      t_src;
      t_pol;
      t_latch;
      end_of_test;
   end
   // Watchdog, well beyond the expected run
   initial
   begin
      #200000;
      fail_count++;
      end_of_test;
   end
endmodule : pwm_fault_select_and_secondary_trigger_bench
`default_nettype wire
